// ==== rtl/sacp_pkg.sv ====
// sacp_pkg: register map, field positions, reset values and carrier types
// for the scsi protection-code and dt crc block.
// assumes a 32-bit apb slave with word-aligned registers.
package sacp_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [11:0] PROT_CTRL0_IDX = 12'h0be;
  localparam logic [11:0] PROT_CTRL1_IDX = 12'h0bf;
  localparam logic [11:0] CRC_PAD_IDX = 12'h0e0;
  localparam logic [11:0] CRC_CTRL0_IDX = 12'h0e2;
  localparam logic [11:0] CRC_CTRL1_IDX = 12'h0e3;
  localparam logic [11:0] CRC_VIEW_IDX = 12'h0e4;
  localparam logic [11:0] PROT_CTRL0_ADDR = 12'(PROT_CTRL0_IDX * 4);
  localparam logic [11:0] PROT_CTRL1_ADDR = 12'(PROT_CTRL1_IDX * 4);
  localparam logic [11:0] CRC_PAD_ADDR = 12'(CRC_PAD_IDX * 4);
  localparam logic [11:0] CRC_CTRL0_ADDR = 12'(CRC_CTRL0_IDX * 4);
  localparam logic [11:0] CRC_CTRL1_ADDR = 12'(CRC_CTRL1_IDX * 4);
  localparam logic [11:0] CRC_VIEW_ADDR = 12'(CRC_VIEW_IDX * 4);
  // ==========================================================
  // field positions
  localparam int FORCE_BAD_BIT = 7;
  localparam int SEQ_RESET_BIT = 6;
  localparam int SEQ_LSB = 4;
  localparam int ERR_LIVE_BIT = 7;
  localparam int ERR_LATCH_BIT = 6;
  localparam int CHK_DIS_BIT = 7;
  localparam int PROTO_DIS_BIT = 6;
  localparam int IVL_RESET_BIT = 5;
  localparam int CRC_ERR_BIT = 7;
  localparam int AUTO_SEED_BIT = 5;
  localparam int TEST_SEED_BIT = 4;
  localparam int TEST_CHECK_BIT = 3;
  localparam int TEST_ACC_BIT = 2;
  // ==========================================================
  // reset values and crc constants
  localparam logic [15:0] PAD_RESET = 16'h0000;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_SEED = 32'hffffffff;
  localparam logic [3:0] IVL_CODE_MAX = 4'ha;
  localparam logic [16:0] IVL_BASE = 17'h00080; // 128 bytes
  // parity masks over {seq[1:0], rsvd[1:0], phase[2:0], data[7:0]}
  localparam logic [14:0] PROT_MASK [6] = '{
    15'h40ff, 15'h20f0, 15'h1ccc, 15'h5aaa, 15'h3e0f, 15'h6733};
  // ==========================================================
  // view selector codes
  typedef enum logic [1:0] {
    SACP_VIEW_CRC, SACP_VIEW_INPUT, SACP_VIEW_ACC, SACP_VIEW_BAD
  } sacp_view_e;
  // signals from the scsi bus side and the interrupt logic
  typedef struct packed {
    logic [7:0] data;
    logic [2:0] phase;
    logic [1:0] rsvd;
    logic async_strobe;
    logic code_strobe;
    logic [5:0] rx_code;
    logic dt_strobe;
    logic dt_phase;
    logic dt_data_in;
    logic target_mode;
    logic crc_check;
    logic [31:0] rx_crc;
    logic seed_req;
    logic protocol_err;
    logic pad_req;
    logic interrupt_status_zero_clear;
    logic sist_read_both;
    logic par_int_en;
  } sacp_bus_in_s;
endpackage : sacp_pkg

// ==== rtl/sacp_core.sv ====
// sacp_core: protection-code generator and checker for asynchronous phases
// and crc engine with interval requests for dt data phases, apb registers.
// assumes bus inputs are synchronous to clk_i and strobes last one cycle.
`timescale 1ns/1ps
module sacp_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire sacp_pkg::sacp_bus_in_s bus_i,
  output logic [5:0] tx_code_o,
  output logic [15:0] pad_data_o,
  output logic crc_req_o,
  output logic gross_error_o,
  output logic interrupt_status_zero_crc_o
);
  // ==========================================================
  // helper functions
  // crc-32 over the top n bits of a word, msb first
  function automatic logic [31:0] crc_upd(input logic [31:0] c,
      input logic [31:0] d, input int n);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 32; i++) begin
      if (i < n) begin
        r = {r[30:0], 1'b0} ^ ((r[31] ^ d[31-i]) ? sacp_pkg::CRC_POLY
            : 32'h0);
      end
    end
    return r;
  endfunction

  function automatic logic is_addr(input logic [11:0] a,
      input logic [11:0] b);
    return a == b;
  endfunction
  // ==========================================================
  // state
  logic force_bad_r, force_bad_nxt, err_live_r, err_live_nxt;
  logic err_latch_r, err_latch_nxt, chk_dis_r, chk_dis_nxt;
  logic proto_dis_r, proto_dis_nxt, crc_err_r, crc_err_nxt;
  logic auto_seed_r, auto_seed_nxt, pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt, crc_req_r, crc_req_nxt;
  logic gross_r, gross_nxt, interrupt_status_zero_r, interrupt_status_zero_nxt;
  logic [1:0] seq_r, seq_nxt, view_r, view_nxt;
  logic [2:0] phase_r, phase_nxt;
  logic [3:0] ivl_code_r, ivl_code_nxt;
  logic [5:0] code_r, code_nxt, tx_code_r, tx_code_nxt;
  logic [15:0] pad_r, pad_nxt, pad_out_r, pad_out_nxt;
  logic [16:0] ivl_cnt_r, ivl_cnt_nxt;
  logic [31:0] acc_r, acc_nxt, inp_r, inp_nxt;
  logic [31:0] bad_r, bad_nxt, prdata_r, prdata_nxt;
  logic wr_en, rd_en, hit;
  logic [14:0] prot_in;
  logic [5:0] code_calc;
  logic [16:0] ivl_len;
  logic mismatch, check_now, ivl_on;
  logic [31:0] view_val;
  // one clock domain, so every assertion below shares these defaults
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // apb decode: a write takes effect on the edge with pready high
  assign wr_en = psel_i & penable_i & pready_r & pwrite_i & ~pslverr_r;
  assign rd_en = psel_i & penable_i & ~pready_r;
  assign hit = is_addr(paddr_i, sacp_pkg::PROT_CTRL0_ADDR)
      | is_addr(paddr_i, sacp_pkg::PROT_CTRL1_ADDR)
      | is_addr(paddr_i, sacp_pkg::CRC_PAD_ADDR)
      | is_addr(paddr_i, sacp_pkg::CRC_CTRL0_ADDR)
      | is_addr(paddr_i, sacp_pkg::CRC_CTRL1_ADDR)
      | is_addr(paddr_i, sacp_pkg::CRC_VIEW_ADDR);

  // code calc: one parity per output bit over its masked inputs
  assign prot_in = {seq_r, bus_i.rsvd, bus_i.phase, bus_i.data};
  for (genvar g = 0; g < 6; g++) begin : g_code
    assign code_calc[g] = ^(prot_in & sacp_pkg::PROT_MASK[g]);
  end

  // interval decode: 128 bytes doubling per code step
  assign ivl_len = sacp_pkg::IVL_BASE << (ivl_code_r - 4'h1);
  // zero and reserved codes give no automatic requests
  assign ivl_on = (ivl_code_r != 4'h0)
      & (ivl_code_r <= sacp_pkg::IVL_CODE_MAX);

  // a test check raises a mismatch just like a bus check
  assign check_now = (bus_i.crc_check & bus_i.dt_data_in)
      | (wr_en & is_addr(paddr_i, sacp_pkg::CRC_CTRL1_ADDR)
         & pwdata_i[sacp_pkg::TEST_CHECK_BIT]);
  // test checks compare against the input word, bus checks against rx
  assign mismatch = check_now & (acc_r != (bus_i.crc_check
      ? ~bus_i.rx_crc : ~inp_r));

  always_comb begin
    case (sacp_pkg::sacp_view_e'(view_r))
      // running crc is the inverted accumulator
      sacp_pkg::SACP_VIEW_CRC: view_val = ~acc_r;
      sacp_pkg::SACP_VIEW_INPUT: view_val = inp_r;
      sacp_pkg::SACP_VIEW_ACC: view_val = acc_r;
      sacp_pkg::SACP_VIEW_BAD: view_val = bad_r;
      default: view_val = 32'h0;
    endcase
  end
  // ==========================================================
  // apb answer: one wait cycle, then registered data and pready
  always_comb begin
    pready_nxt = rd_en;
    pslverr_nxt = rd_en & ~hit;
    prdata_nxt = 32'h0;
    if (rd_en & ~pwrite_i) begin
      if (is_addr(paddr_i, sacp_pkg::PROT_CTRL0_ADDR)) begin
        prdata_nxt = {24'h0, force_bad_r, 1'b0, seq_r, 4'h0};
      end else if (is_addr(paddr_i, sacp_pkg::PROT_CTRL1_ADDR)) begin
        prdata_nxt = {24'h0, err_live_r, err_latch_r, code_r};
      end else if (is_addr(paddr_i, sacp_pkg::CRC_PAD_ADDR)) begin
        prdata_nxt = {16'h0, pad_r};
      end else if (is_addr(paddr_i, sacp_pkg::CRC_CTRL0_ADDR)) begin
        prdata_nxt = {24'h0, chk_dis_r, proto_dis_r, 2'b00, ivl_code_r};
      end else if (is_addr(paddr_i, sacp_pkg::CRC_CTRL1_ADDR)) begin
        prdata_nxt = {24'h0, crc_err_r, 1'b0, auto_seed_r, 3'b000,
            view_r};
      end else if (is_addr(paddr_i, sacp_pkg::CRC_VIEW_ADDR)) begin
        prdata_nxt = view_val;
      end
    end
  end
  // ==========================================================
  // protection-code state
  always_comb begin
    force_bad_nxt = force_bad_r;
    seq_nxt = seq_r;
    phase_nxt = bus_i.phase;
    code_nxt = code_calc;
    // live compare, may flag transient errors
    err_live_nxt = bus_i.code_strobe & (bus_i.rx_code != code_calc);
    err_latch_nxt = err_latch_r;
    if (bus_i.async_strobe) begin
      seq_nxt = seq_r + 2'd1;
    end
    if (bus_i.phase != phase_r) begin
      seq_nxt = 2'd0;
    end
    if (wr_en && is_addr(paddr_i, sacp_pkg::PROT_CTRL0_ADDR)) begin
      force_bad_nxt = pwdata_i[sacp_pkg::FORCE_BAD_BIT];
      if (pwdata_i[sacp_pkg::SEQ_RESET_BIT]) begin
        seq_nxt = 2'd0;
      end
    end
    // latched error, set wins over clear
    if (bus_i.interrupt_status_zero_clear) begin
      err_latch_nxt = 1'b0;
    end
    if (err_live_nxt) begin
      err_latch_nxt = 1'b1;
    end
  end
  // ==========================================================
  // crc control and data state
  always_comb begin
    pad_nxt = pad_r;
    chk_dis_nxt = chk_dis_r;
    proto_dis_nxt = proto_dis_r;
    ivl_code_nxt = ivl_code_r;
    ivl_cnt_nxt = ivl_cnt_r;
    crc_err_nxt = crc_err_r;
    auto_seed_nxt = auto_seed_r;
    view_nxt = view_r;
    acc_nxt = acc_r;
    inp_nxt = inp_r;
    bad_nxt = bad_r;
    crc_req_nxt = 1'b0;
    // bytes fold into the crc-32 accumulator
    if (bus_i.dt_strobe) begin
      inp_nxt = {inp_r[23:0], bus_i.data};
      acc_nxt = crc_upd(acc_r, {bus_i.data, 24'h0}, 8);
    end
    // interval counting runs across block moves
    if (bus_i.dt_strobe && bus_i.target_mode && bus_i.dt_phase
        && ivl_on) begin
      if (ivl_cnt_r + 17'd1 >= ivl_len) begin
        ivl_cnt_nxt = 17'd0;
        crc_req_nxt = 1'b1;
      end else begin
        ivl_cnt_nxt = ivl_cnt_r + 17'd1;
      end
    end
    // reseed after each check while auto seed is on, or on bus control request while it is off
    if ((check_now && auto_seed_r) || (bus_i.seed_req && !auto_seed_r))
        begin
      acc_nxt = sacp_pkg::CRC_SEED;
    end
    // clears first so a same-cycle error still sets
    if (bus_i.sist_read_both) begin
      crc_err_nxt = 1'b0;
    end
    if (wr_en && is_addr(paddr_i, sacp_pkg::CRC_PAD_ADDR)) begin
      pad_nxt = pwdata_i[15:0];
    end
    if (wr_en && is_addr(paddr_i, sacp_pkg::CRC_CTRL0_ADDR)) begin
      chk_dis_nxt = pwdata_i[sacp_pkg::CHK_DIS_BIT];
      proto_dis_nxt = pwdata_i[sacp_pkg::PROTO_DIS_BIT];
      ivl_code_nxt = pwdata_i[3:0];
      // interval counter reset, bit not stored
      if (pwdata_i[sacp_pkg::IVL_RESET_BIT]) begin
        ivl_cnt_nxt = 17'd0;
      end
    end
    if (wr_en && is_addr(paddr_i, sacp_pkg::CRC_CTRL1_ADDR)) begin
      auto_seed_nxt = pwdata_i[sacp_pkg::AUTO_SEED_BIT];
      view_nxt = pwdata_i[1:0];
      if (pwdata_i[sacp_pkg::CRC_ERR_BIT]) begin
        crc_err_nxt = 1'b0;
      end
      // test accumulate folds whole input word
      if (pwdata_i[sacp_pkg::TEST_ACC_BIT]) begin
        acc_nxt = crc_upd(acc_r, inp_r, 32);
      end
      // test seed wins over everything else on the accumulator
      if (pwdata_i[sacp_pkg::TEST_SEED_BIT]) begin
        acc_nxt = sacp_pkg::CRC_SEED;
      end
    end
    // input and accumulator writable through the view
    if (wr_en && is_addr(paddr_i, sacp_pkg::CRC_VIEW_ADDR)) begin
      if (view_r == 2'(sacp_pkg::SACP_VIEW_INPUT)) begin
        inp_nxt = pwdata_i;
      end else if (view_r == 2'(sacp_pkg::SACP_VIEW_ACC)) begin
        acc_nxt = pwdata_i;
      end
    end
    // flag sets regardless of the check disable
    if (mismatch) begin
      crc_err_nxt = 1'b1;
    end
    // capture only while no error is pending
    if (mismatch && !crc_err_r) begin
      bad_nxt = ~acc_r;
    end
  end
  // ==========================================================
  // bus-facing outputs, all registered
  always_comb begin
    tx_code_nxt = force_bad_r ? ~code_calc : code_calc;
    // pad value driven while pad bytes are due
    pad_out_nxt = bus_i.pad_req ? pad_r : 16'h0;
    gross_nxt = bus_i.protocol_err & ~proto_dis_r;
    // report only when checking and interrupt enabled
    interrupt_status_zero_nxt = mismatch & ~chk_dis_r & bus_i.par_int_en;
  end

  // one register stage for every group above
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      force_bad_r <= 1'b0;
      seq_r <= 2'd0;
      phase_r <= 3'd0;
      err_live_r <= 1'b0;
      err_latch_r <= 1'b0;
      code_r <= 6'h0;
      pad_r <= sacp_pkg::PAD_RESET;
      chk_dis_r <= 1'b0;
      proto_dis_r <= 1'b0;
      ivl_code_r <= 4'h0;
      ivl_cnt_r <= 17'd0;
      crc_err_r <= 1'b0;
      auto_seed_r <= 1'b0;
      view_r <= 2'd0;
      acc_r <= sacp_pkg::CRC_SEED;
      inp_r <= 32'h0;
      bad_r <= 32'h0;
      prdata_r <= 32'h0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      tx_code_r <= 6'h0;
      pad_out_r <= 16'h0;
      crc_req_r <= 1'b0;
      gross_r <= 1'b0;
      interrupt_status_zero_r <= 1'b0;
    end else begin
      force_bad_r <= force_bad_nxt;
      seq_r <= seq_nxt;
      phase_r <= phase_nxt;
      err_live_r <= err_live_nxt;
      err_latch_r <= err_latch_nxt;
      code_r <= code_nxt;
      pad_r <= pad_nxt;
      chk_dis_r <= chk_dis_nxt;
      proto_dis_r <= proto_dis_nxt;
      ivl_code_r <= ivl_code_nxt;
      ivl_cnt_r <= ivl_cnt_nxt;
      crc_err_r <= crc_err_nxt;
      auto_seed_r <= auto_seed_nxt;
      view_r <= view_nxt;
      acc_r <= acc_nxt;
      inp_r <= inp_nxt;
      bad_r <= bad_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      tx_code_r <= tx_code_nxt;
      pad_out_r <= pad_out_nxt;
      crc_req_r <= crc_req_nxt;
      gross_r <= gross_nxt;
      interrupt_status_zero_r <= interrupt_status_zero_nxt;
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
  assign tx_code_o = tx_code_r;
  assign pad_data_o = pad_out_r;
  assign crc_req_o = crc_req_r;
  assign gross_error_o = gross_r;
  assign interrupt_status_zero_crc_o = interrupt_status_zero_r;
  // ==========================================================
  // assertions
  property p_force_bad;
    force_bad_r |=> tx_code_o == ~$past(code_calc);
  endproperty
  a_force_bad: assert property (p_force_bad)
    else $error("forced code not inverted");
  property p_seq_phase;
    (bus_i.phase != phase_r) |=> seq_r == 2'd0;
  endproperty
  a_seq_phase: assert property (p_seq_phase)
    else $error("sequence not cleared on phase change");
  property p_latch; err_live_r |-> err_latch_r; endproperty
  a_latch: assert property (p_latch)
    else $error("live error not latched");
  property p_pad; bus_i.pad_req |=> pad_data_o == $past(pad_r); endproperty
  a_pad: assert property (p_pad)
    else $error("pad value not driven");
  property p_chk_dis; chk_dis_r |=> !interrupt_status_zero_crc_o; endproperty
  a_chk_dis: assert property (p_chk_dis)
    else $error("crc error reported while disabled");
  property p_proto;
    (bus_i.protocol_err && !proto_dis_r) |=> gross_error_o;
  endproperty
  a_proto: assert property (p_proto)
    else $error("gross error missing");
  property p_ivl_off; (ivl_code_r == 4'h0) |=> !crc_req_o; endproperty
  a_ivl_off: assert property (p_ivl_off)
    else $error("crc request with interval disabled");
  property p_crc_flag; mismatch |=> crc_err_r; endproperty
  a_crc_flag: assert property (p_crc_flag)
    else $error("crc mismatch did not set flag");
  property p_bad_hold;
    (crc_err_r && $past(crc_err_r)) |-> $stable(bad_r);
  endproperty
  a_bad_hold: assert property (p_bad_hold)
    else $error("saved bad crc overwritten");
  property p_apb_wait;
    (psel_i && penable_i && !pready_o) |=> pready_o;
  endproperty
  a_apb_wait: assert property (p_apb_wait)
    else $error("apb answer late");
  c_req: cover property (crc_req_o);
  c_err: cover property (interrupt_status_zero_crc_o);
  c_live: cover property (err_live_r ##1 err_latch_r);
endmodule // sacp_core

// ==== verification/sacp_scsi_peer.sv ====
// sacp_scsi_peer: behavioural scsi initiator/target on the bus side.
// assumes clk_i free running; every change lands just after a rising edge.
`timescale 1ns/1ps
module sacp_scsi_peer (
  input wire logic clk_i,
  output sacp_pkg::sacp_bus_in_s bus_o
);
  // ==========================================================
  // line state, also set directly by the bench for levels
  sacp_pkg::sacp_bus_in_s b;
  initial b = '0;
  assign bus_o = b;

  // ==========================================================
  // one-cycle events {async, code, check, seed, proto, clr, rdboth}
  task automatic ev(input logic [6:0] m);
    @(posedge clk_i);
    {b.async_strobe, b.code_strobe, b.crc_check, b.seed_req,
      b.protocol_err, b.interrupt_status_zero_clear, b.sist_read_both} <= m;
    @(posedge clk_i);
    {b.async_strobe, b.code_strobe, b.crc_check, b.seed_req,
      b.protocol_err, b.interrupt_status_zero_clear, b.sist_read_both} <= 7'h00;
  endtask

  // back-to-back dt bytes counting up; data inverted after the burst
  // so a stale byte can never pass for a fresh one
  task automatic dt_burst(input logic [7:0] d0, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      b.data <= d0 + 8'(i);
      b.dt_strobe <= 1'b1;
    end
    @(posedge clk_i);
    b.dt_strobe <= 1'b0;
    b.data <= ~b.data;
  endtask
endmodule // sacp_scsi_peer

// ==== verification/scsi_aip_crc_protection_test.sv ====
// scsi_aip_crc_protection_test: apb register tests plus scsi-side traffic.
// assumes sacp_core answers apb with a wait state and a peer model.
`timescale 1ns/1ps
module scsi_aip_crc_protection_test;
  // ==========================================================
  // addresses and event masks
  localparam logic [11:0] PC0 = sacp_pkg::PROT_CTRL0_ADDR;
  localparam logic [11:0] PC1 = sacp_pkg::PROT_CTRL1_ADDR;
  localparam logic [11:0] PAD = sacp_pkg::CRC_PAD_ADDR;
  localparam logic [11:0] CC0 = sacp_pkg::CRC_CTRL0_ADDR;
  localparam logic [11:0] CC1 = sacp_pkg::CRC_CTRL1_ADDR;
  localparam logic [11:0] VW = sacp_pkg::CRC_VIEW_ADDR;
  localparam logic [11:0] REGS [6] = '{PC0, PC1, PAD, CC0, CC1, VW};
  localparam logic [6:0] E_ASY = 7'h40;
  localparam logic [6:0] E_CODE = 7'h20;
  localparam logic [6:0] E_CHK = 7'h10;
  localparam logic [6:0] E_SEED = 7'h08;
  localparam logic [6:0] E_PRO = 7'h04;
  localparam logic [6:0] E_CLR = 7'h02;
  localparam logic [6:0] E_RDB = 7'h01;
  localparam logic [31:0] M = 32'hffffffff;
  logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat, e, a;
  logic [5:0] tx_code;
  logic [15:0] pad_data;
  logic crc_req, gross, interrupt_status_zero;
  sacp_pkg::sacp_bus_in_s bus;
  int fails, n_tests, n_req, n_gross, n_sist;

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  sacp_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .bus_i(bus), .tx_code_o(tx_code),
    .pad_data_o(pad_data), .crc_req_o(crc_req), .gross_error_o(gross),
    .interrupt_status_zero_crc_o(interrupt_status_zero));
  sacp_scsi_peer peer_u (.clk_i(clk_i), .bus_o(bus));

  // ==========================================================
  // pulse counters, sampled where the pulses have settled
  always @(posedge clk_i) begin
    if (crc_req === 1'b1) n_req++;
    if (gross === 1'b1) n_gross++;
    if (interrupt_status_zero === 1'b1) n_sist++;
  end

  // ==========================================================
  // reporting
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // ==========================================================
  // apb master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] ad,
    input logic [31:0] wd);
    int k;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      fails++;
      end_sim();
    end
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask

  task automatic rc(input logic [11:0] ad, input logic [31:0] m,
    input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    chk(rdat & m, x);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_i);
  endtask

  // ==========================================================
  // reference models kept apart from the design's own logic
  function automatic logic [5:0] pcode(input logic [14:0] vv);
    for (int i = 0; i < 6; i++) pcode[i] = ^(sacp_pkg::PROT_MASK[i] & vv);
  endfunction

  function automatic logic [31:0] crc(input logic [31:0] c,
    input logic [31:0] d, input int n);
    for (int i = n - 1; i >= 0; i--)
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? sacp_pkg::CRC_POLY : 32'h0);
    return c;
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    rst_i = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {fails, n_tests, n_req, n_gross, n_sist} = '0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) rc(REGS[i], M, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, perr}, 32'h1);
    wr(PAD, 32'h0001a55a);
    rc(PAD, M, 32'h0000a55a);
    peer_u.b.pad_req <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({16'h0, pad_data}, 32'ha55a);
    peer_u.b.pad_req <= 1'b0;
    // protection code and sequence count
    peer_u.b.data <= 8'h5c;
    peer_u.b.phase <= 3'h2;
    peer_u.b.rsvd <= 2'h1;
    repeat (3) peer_u.ev(E_ASY);
    rc(PC1, 32'h3f, {26'h0, pcode({4'hd, 3'h2, 8'h5c})});
    rc(PC0, 32'hff, 32'h30);
    wr(PC0, 32'h80);
    rc(PC0, 32'hff, 32'hb0);
    chk({26'h0, tx_code}, {26'h0, ~pcode({4'hd, 3'h2, 8'h5c})});
    wr(PC0, 32'h40);
    rc(PC0, 32'hff, 32'h0);
    repeat (2) peer_u.ev(E_ASY);
    peer_u.b.phase <= 3'h3;
    rc(PC0, 32'hff, 32'h0);
    peer_u.b.rx_code <= ~pcode({4'h1, 3'h3, 8'h5c});
    peer_u.ev(E_CODE);
    rc(PC1, 32'hc0, 32'h40);
    peer_u.ev(E_CLR);
    rc(PC1, 32'hc0, 32'h0);
    // gross error gating
    peer_u.ev(E_PRO);
    wr(CC0, 32'h40);
    peer_u.ev(E_PRO);
    settle();
    chk(32'(n_gross), 32'h1);
    wr(CC0, 32'h0);
    // crc engine and views
    wr(CC1, 32'h10);
    rc(VW, M, 32'h0);
    peer_u.dt_burst(8'h31, 9);
    e = M;
    for (int i = 0; i < 9; i++) e = crc(e, 32'h31 + i, 8);
    rc(VW, M, ~e);
    peer_u.ev(E_SEED);
    rc(VW, M, 32'h0);
    wr(CC1, 32'h2);
    wr(VW, 32'h0badf00d);
    rc(VW, M, 32'h0badf00d);
    wr(CC1, 32'h0);
    wr(VW, 32'h1);
    rc(VW, M, ~32'h0badf00d);
    wr(CC1, 32'h1);
    wr(VW, 32'h12345678);
    rc(VW, M, 32'h12345678);
    wr(CC1, 32'h4);
    a = crc(32'h0badf00d, 32'h12345678, 32);
    rc(VW, M, ~a);
    wr(CC1, 32'h8);
    rc(CC1, 32'h80, 32'h80);
    wr(CC1, 32'h3);
    rc(VW, M, ~a);
    wr(CC1, 32'h80);
    rc(CC1, 32'hff, 32'h0);
    // received checks with auto seed
    peer_u.b.dt_data_in <= 1'b1;
    peer_u.b.par_int_en <= 1'b1;
    wr(CC1, 32'h30);
    peer_u.dt_burst(8'h31, 9);
    peer_u.b.rx_crc <= ~e;
    peer_u.ev(E_CHK);
    rc(CC1, 32'h80, 32'h0);
    rc(VW, M, 32'h0);
    peer_u.dt_burst(8'h31, 9);
    peer_u.b.rx_crc <= e;
    peer_u.ev(E_CHK);
    rc(CC1, 32'h80, 32'h80);
    chk(32'(n_sist), 32'h1);
    wr(CC1, 32'h23);
    rc(VW, M, ~e);
    peer_u.dt_burst(8'h00, 1);
    peer_u.ev(E_CHK);
    rc(VW, M, ~e);
    // a second error while checking is enabled reports again
    chk(32'(n_sist), 32'h2);
    peer_u.ev(E_RDB);
    rc(CC1, 32'h80, 32'h0);
    wr(CC0, 32'h80);
    peer_u.dt_burst(8'h31, 3);
    peer_u.ev(E_CHK);
    rc(CC1, 32'h80, 32'h80);
    chk(32'(n_sist), 32'h2);
    wr(CC1, 32'ha0);
    wr(CC0, 32'h0);
    // target-mode request interval
    peer_u.b.dt_data_in <= 1'b0;
    peer_u.b.target_mode <= 1'b1;
    peer_u.b.dt_phase <= 1'b1;
    wr(CC0, 32'h21);
    rc(CC0, 32'hff, 32'h01);
    peer_u.dt_burst(8'h0, 64);
    settle();
    peer_u.dt_burst(8'h0, 63);
    settle();
    chk(32'(n_req), 32'h0);
    peer_u.dt_burst(8'h0, 1);
    settle();
    chk(32'(n_req), 32'h1);
    peer_u.dt_burst(8'h0, 100);
    wr(CC0, 32'h21);
    peer_u.dt_burst(8'h0, 127);
    settle();
    chk(32'(n_req), 32'h1);
    peer_u.dt_burst(8'h0, 1);
    settle();
    chk(32'(n_req), 32'h2);
    wr(CC0, 32'h22);
    peer_u.dt_burst(8'h0, 255);
    settle();
    chk(32'(n_req), 32'h2);
    peer_u.dt_burst(8'h0, 1);
    settle();
    chk(32'(n_req), 32'h3);
    wr(CC0, 32'h20);
    peer_u.dt_burst(8'h0, 300);
    settle();
    chk(32'(n_req), 32'h3);
    wr(CC0, 32'h2b);
    peer_u.dt_burst(8'h0, 300);
    settle();
    chk(32'(n_req), 32'h3);
    end_sim();
  end
endmodule // scsi_aip_crc_protection_test
